// ### hdl/flash_status_protect.sv
// Purpose: Status write protection, lock reload and configuration register
// Assumes: SPI mode 0, serial clock well below ref_clk/4
// Notes:   Serial clock edges are found by sampling, not used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_regs.svh"
module flash_status_protect
  import flash_prot_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Serial pins
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_si,
  input  wire logic       write_protect_pin_n,
  input  wire logic       hold_reset_pin_n,
  output logic            spi_so,
  output logic            spi_so_oe,
  // Nonvolatile copies
  input  wire logic       nv_lock_mode_hi,
  input  wire logic       nv_lock_mode_lo,
  input  wire logic       permanent_lock_fuse,
  // Block controls
  output logic            quad_enable,
  output logic [1:0]      output_strength,
  output logic            protect_scheme_select,
  output logic            hold_active,
  output logic            block_locks_set,
  output logic            status_write_locked
);
  pin_sync_if pins ();
  pin_sync u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pins    (pins.syncer)
  );
  assign pins.raw = {hold_reset_pin_n, write_protect_pin_n, spi_si,
                     spi_cs_n, spi_sclk};

  function automatic logic [1:0] reload_map(input logic [1:0] nv,
                                            input logic fuse);
    unique case (nv)
      2'b00:   reload_map = 2'b00;
      2'b01:   reload_map = 2'b01;
      2'b10:   reload_map = 2'b00;
      2'b11:   reload_map = fuse ? 2'b11 : 2'b01;
    endcase
  endfunction : reload_map

  frame_e     state_r;
  frame_e     state_nxt;
  byte_t      shift_r;
  byte_t      cmd_r;
  byte_t      data_r;
  byte_t      out_r;
  byte_t      cfg_r;
  logic [2:0] bit_cnt_r;
  logic       sclk_d_r;
  logic       cs_d_r;
  logic       lock_hi_r;
  logic       lock_lo_r;
  logic       wel_r;
  logic       qe_r;
  logic       rst_armed_r;
  logic       reload_r;
  logic       blk_set_r;
  logic       hold_act_r;
  logic       locked_r;
  logic       so_oe_r;

  // Synced pins
  wire sclk_s = pins.sync[0];
  wire cs_n_s = pins.sync[1];
  wire si_s   = pins.sync[2];
  wire wp_s   = pins.sync[3];
  wire hold_s = pins.sync[4];

  // Pin roles
  wire hold_fn    = cfg_r[`CFG_HOLD_RST];
  wire hold_pause = ~qe_r & ~hold_fn & ~hold_s;
  wire hw_reset   = ~qe_r & hold_fn & ~hold_s;
  wire wp_eff     = qe_r | wp_s;

  // Edge finding; pause freezes the shifter
  wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s & ~hold_pause;
  wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s & ~hold_pause;
  wire cs_rise   = cs_n_s & ~cs_d_r;
  wire byte_done = sclk_rise & (bit_cnt_r == `BIT_LAST);
  wire [7:0] shift_nxt = {shift_r[6:0], si_s};

  // Protection decode
  wire locked   = lock_hi_r | (lock_lo_r & ~wp_eff);
  wire write_ok = wel_r & ~locked;

  // Command decode at end of frame
  wire one_byte = cs_rise & (state_r == FR_DATA);
  wire two_byte = cs_rise & (state_r == FR_DONE);
  wire is_sr0   = cmd_r == `OP_WRSR0;
  wire is_sr2   = (cmd_r == `OP_WRSR2) | (cmd_r == `OP_WRSR2B);
  wire is_cfg   = cmd_r == `OP_WRCFG;
  wire wr_cmd   = two_byte & (is_sr0 | is_sr2 | is_cfg);
  wire wr_take  = wr_cmd & write_ok;
  wire wr_drop  = wr_cmd & ~write_ok;
  wire do_wren  = one_byte & (cmd_r == `OP_WREN);
  wire do_wrdi  = one_byte & (cmd_r == `OP_WRDI);
  wire do_rsten = one_byte & (cmd_r == `OP_RSTEN);
  wire sw_reset = one_byte & (cmd_r == `OP_RST) & rst_armed_r;
  wire any_rst  = sw_reset | hw_reset;

  // Read path
  wire [7:0] sr0_rd = (8'(lock_lo_r) << `SR0_LOCK_LO) |
                      (8'(wel_r) << `SR0_WEL);
  wire [7:0] sr2_rd = (8'(lock_hi_r) << `SR2_LOCK_HI) |
                      (8'(qe_r) << `SR2_QE);
  wire [7:0] rd_cmd = (state_r == FR_CMD) ? shift_nxt : cmd_r;
  wire       rd_sr0 = rd_cmd == `OP_RDSR0;
  wire       rd_sr2 = rd_cmd == `OP_RDSR2;
  wire       rd_cfg = rd_cmd == `OP_RDCFG;
  wire       is_rd  = rd_sr0 | rd_sr2 | rd_cfg;
  wire [7:0] rd_val = rd_sr0 ? sr0_rd : (rd_sr2 ? sr2_rd :
                      (rd_cfg ? cfg_r : 8'h00));

  always_comb begin
    state_nxt = state_r;
    if (cs_n_s) begin
      state_nxt = FR_CMD;
    end else if (byte_done) begin
      unique case (state_r)
        FR_CMD:  state_nxt = FR_DATA;
        FR_DATA: state_nxt = FR_DONE;
        FR_DONE: state_nxt = FR_OVER;
        FR_OVER: state_nxt = FR_OVER;
      endcase
    end
  end

  // Serial shifter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= FR_CMD;
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      cmd_r     <= 8'h00;
      data_r    <= 8'h00;
      sclk_d_r  <= 1'b0;
      cs_d_r    <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_n_s;
      if (cs_n_s) begin
        bit_cnt_r <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_r   <= shift_nxt;
      end
      if (byte_done && state_r == FR_CMD) begin
        cmd_r <= shift_nxt;
      end
      if (byte_done && state_r == FR_DATA) begin
        data_r <= shift_nxt;
      end
    end
  end

  // Read shifter; answer loads on the rising edge of the last command bit, later bits change on falling serial clock edges
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r   <= 8'h00;
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= ~cs_n_s & (state_r != FR_CMD) & is_rd;
      if (byte_done && is_rd) begin
        out_r <= rd_val;
      end else if (sclk_fall && bit_cnt_r != 3'h0) begin
        out_r <= {out_r[6:0], 1'b0};
      end
    end
  end

  // Lock pair and write enable; with lock_hi_r set, locked state held until reload
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_hi_r   <= 1'b1;
      lock_lo_r   <= 1'b1;
      wel_r       <= 1'b0;
      qe_r        <= 1'b0;
      rst_armed_r <= 1'b0;
      reload_r    <= 1'b1;
    end else begin
      reload_r    <= any_rst;
      rst_armed_r <= do_rsten | (rst_armed_r & ~one_byte & ~two_byte);
      if (reload_r) begin
        {lock_hi_r, lock_lo_r} <= reload_map({nv_lock_mode_hi,
          nv_lock_mode_lo}, permanent_lock_fuse);
        wel_r <= 1'b0;
      end else begin
        if (wr_take && is_sr0) begin
          lock_lo_r <= data_r[`SR0_LOCK_LO];
        end
        if (wr_take && is_sr2) begin
          lock_hi_r <= data_r[`SR2_LOCK_HI];
          qe_r      <= data_r[`SR2_QE];
        end
        if (do_wren) begin
          wel_r <= 1'b1;
        end else if (do_wrdi || wr_take) begin
          wel_r <= 1'b0;
        end
      end
    end
  end

  // Configuration register and block outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r      <= `CFG_RESET;
      blk_set_r  <= 1'b0;
      hold_act_r <= 1'b0;
      locked_r   <= 1'b1;
    end else begin
      if (wr_take && is_cfg && !reload_r) begin
        cfg_r <= data_r & `CFG_WMASK;
      end
      blk_set_r  <= reload_r;
      hold_act_r <= hold_pause;
      locked_r   <= locked;
    end
  end

  assign spi_so                = out_r[7];
  assign spi_so_oe             = so_oe_r;
  assign quad_enable           = qe_r;
  assign output_strength       = cfg_r[`CFG_DRV_HI:`CFG_DRV_LO];
  assign protect_scheme_select = cfg_r[`CFG_WPS];
  assign hold_active           = hold_act_r;
  assign block_locks_set       = blk_set_r;
  assign status_write_locked   = locked_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_open_write;
    wr_cmd && is_cfg && !lock_hi_r && !lock_lo_r && wel_r && !reload_r
      |=> cfg_r == (data_r & `CFG_WMASK) && !wel_r;
  endproperty
  a_open_write: assert property (p_open_write)
    else $error("open write not taken");

  property p_hw_protected;
    wr_cmd && !lock_hi_r && lock_lo_r && !wp_eff
      |=> $stable(cfg_r) && $stable(qe_r) && $stable(lock_lo_r);
  endproperty
  a_hw_protected: assert property (p_hw_protected)
    else $error("write passed with protect pin low");

  property p_hw_open;
    wr_cmd && is_cfg && !lock_hi_r && lock_lo_r && wp_eff && wel_r
      && !reload_r |=> cfg_r == ($past(data_r) & `CFG_WMASK);
  endproperty
  a_hw_open: assert property (p_hw_open)
    else $error("write refused with protect pin high");

  property p_lockdown;
    wr_cmd && lock_hi_r && !reload_r |=> $stable(cfg_r) ##0 $stable(qe_r);
  endproperty
  a_lockdown: assert property (p_lockdown)
    else $error("write passed during lockdown");

  property p_locked_out;
    lock_hi_r && lock_lo_r && !reload_r |=> status_write_locked;
  endproperty
  a_locked_out: assert property (p_locked_out)
    else $error("pair 11 not reported locked");

  property p_otp;
    reload_r && nv_lock_mode_hi && nv_lock_mode_lo && permanent_lock_fuse
      |=> lock_hi_r && lock_lo_r;
  endproperty
  a_otp: assert property (p_otp)
    else $error("permanent lock lost on reset");

  property p_reload;
    any_rst |=> ##1 {lock_hi_r, lock_lo_r} == reload_map(
      $past({nv_lock_mode_hi, nv_lock_mode_lo}),
      $past(permanent_lock_fuse)) ##0 block_locks_set;
  endproperty
  a_reload: assert property (p_reload)
    else $error("lock pair reload wrong");

  property p_quad_pins;
    qe_r [*2] |-> !hold_active && !hw_reset;
  endproperty
  a_quad_pins: assert property (p_quad_pins)
    else $error("pause or reset active in quad mode");

  property p_refused;
    wr_drop && !reload_r |=> $stable(wel_r) && $stable(cfg_r);
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused write changed state");

  c_take: cover property (wr_take);
  c_drop: cover property (wr_drop);
  c_sw_reset: cover property (sw_reset);
  c_read: cover property (so_oe_r && cmd_r == `OP_RDCFG);
endmodule : flash_status_protect
`default_nettype wire

// ### hdl/pin_sync.sv
// Purpose: Two-flop synchroniser for all serial pins
// Assumes: Pins are asynchronous to ref_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_regs.svh"
module pin_sync (
  // Clock and reset
  input wire logic   ref_clk,
  input wire logic   arst_n,
  // Pins
  pin_sync_if.syncer pins
);
  logic [`SYNC_W-1:0] meta_r;
  logic [`SYNC_W-1:0] sync_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= `SYNC_RESET;
      sync_r <= `SYNC_RESET;
    end else begin
      meta_r <= pins.raw;
      sync_r <= meta_r;
    end
  end

  assign pins.sync = sync_r;
endmodule : pin_sync
`default_nettype wire

// ### inc/flash_prot_pkg.sv
// Purpose: Types shared by the protection block
// Assumes: Nothing beyond the register header
// Notes:   Frame state follows the byte position inside one chip select
package flash_prot_pkg;
  typedef enum logic [1:0] {FR_CMD, FR_DATA, FR_DONE, FR_OVER} frame_e;
  typedef logic [7:0] byte_t;
endpackage : flash_prot_pkg

// ### inc/flash_prot_regs.svh
// Purpose: Opcodes, bit positions and reset values of the protection block
// Assumes: Eight-bit status and configuration registers
// Notes:   Definitions only
`ifndef FLASH_PROT_REGS_SVH
`define FLASH_PROT_REGS_SVH

`define OP_WRSR0      8'h01
`define OP_WRSR2      8'h31
`define OP_WRCFG      8'h11
`define OP_WRSR2B     8'h71
`define OP_WREN       8'h06
`define OP_WRDI       8'h04
`define OP_RDSR0      8'h05
`define OP_RDSR2      8'h35
`define OP_RDCFG      8'h15
`define OP_RSTEN      8'h66
`define OP_RST        8'h99
`define OP_BLKLOCK    8'h36
`define OP_BLKUNLOCK  8'h39

`define SR0_LOCK_LO   7
`define SR0_WEL       1
`define SR2_LOCK_HI   0
`define SR2_QE        1
`define CFG_HOLD_RST  7
`define CFG_DRV_HI    6
`define CFG_DRV_LO    5
`define CFG_WPS       2
`define CFG_RESET     8'h20
`define CFG_WMASK     8'he4

// Pins in sync order {hold, wp, si, cs_n, sclk}
`define SYNC_W        5
`define SYNC_RESET    5'h1a
`define BIT_LAST      3'h7

`endif

// ### inc/pin_sync_if.sv
// Purpose: Carries raw pins to the synchroniser and synced levels back
// Assumes: Width fixed by the register header
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_regs.svh"
interface pin_sync_if;
  logic [`SYNC_W-1:0] raw;
  logic [`SYNC_W-1:0] sync;
  modport syncer (input raw, output sync);
  modport user   (output raw, input sync);
endinterface : pin_sync_if
`default_nettype wire

// ### sim/spi_host_model.sv
// Purpose: SPI host model issuing status and configuration frames
// Assumes: Mode 0, one command per chip select, 48 ns serial clock
// Notes:   Serial clock stands still low between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
  import flash_prot_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_si,
  input  wire logic spi_so,
  input  wire logic spi_so_oe
);
  // Output enable seen when the first answer bit is taken
  logic oe_seen;

  initial begin
    oe_seen  = 1'b0;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // Sends nb bytes of d MSB first; data of the second byte returns in rd
  task automatic xfer(input logic [15:0] d, input int nb, output byte_t rd);
    rd = 8'h00;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 * nb; i++) begin
      spi_si = d[15-i];
      repeat (6) @(negedge ref_clk);
      if (i == 8) oe_seen = spi_so_oe;
      if (i >= 8) rd = {rd[6:0], spi_so};
      spi_sclk = 1'b1;
      repeat (6) @(negedge ref_clk);
      spi_sclk = 1'b0;
    end
    repeat (6) @(negedge ref_clk);
    spi_cs_n = 1'b1;
    // Released line shows the inverse so a stale bit is never trusted
    spi_si = ~spi_si;
    repeat (8) @(negedge ref_clk);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ### sim/status_write_protect_and_config_test.sv
// Purpose: Self-checking bench for status write protection and config
// Assumes: Host model drives the serial pins, bench drives the rest
// Notes:   Loops over every nonvolatile lock combination
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_regs.svh"
module status_write_protect_and_config_test;
  import flash_prot_pkg::*;
  logic       ref_clk, arst_n, spi_sclk, spi_cs_n, spi_si;
  logic       write_protect_pin_n, hold_reset_pin_n, spi_so, spi_so_oe;
  logic       nv_lock_mode_hi, nv_lock_mode_lo, permanent_lock_fuse;
  logic       quad_enable, protect_scheme_select, hold_active;
  logic       block_locks_set, status_write_locked;
  logic [1:0] output_strength, p;
  logic       lk;
  byte_t      v, r, e;
  int         error_cnt, tests_run, pulses, p0;

  flash_status_protect i_flash_status_protect (.ref_clk, .arst_n,
    .spi_sclk, .spi_cs_n, .spi_si, .write_protect_pin_n, .hold_reset_pin_n,
    .spi_so, .spi_so_oe, .nv_lock_mode_hi, .nv_lock_mode_lo,
    .permanent_lock_fuse, .quad_enable, .output_strength,
    .protect_scheme_select, .hold_active, .block_locks_set,
    .status_write_locked);
  spi_host_model i_spi_host_model (.ref_clk, .spi_sclk, .spi_cs_n, .spi_si,
    .spi_so, .spi_so_oe);

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (block_locks_set === 1'b1) pulses++;

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // k holds {nv hi, nv lo, fuse}
  function automatic logic [1:0] exp_pair(logic [2:0] k);
    if (k[2:1] == 2'b11) return k[0] ? 2'b11 : 2'b01;
    return {1'b0, k[1] & ~k[2]};
  endfunction : exp_pair

  function automatic logic exp_lock(logic [1:0] pr, logic wp, logic q);
    return pr[1] | (pr == 2'b01 && !wp && !q);
  endfunction : exp_lock

  task automatic wait_n(int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n

  task automatic wr(byte_t op, byte_t d);
    byte_t x;
    i_spi_host_model.xfer({`OP_WREN, 8'h00}, 1, x);
    i_spi_host_model.xfer({op, d}, 2, x);
  endtask : wr

  task automatic rd(byte_t op, output byte_t d);
    i_spi_host_model.xfer({op, 8'h00}, 2, d);
  endtask : rd

  task automatic arst(logic [2:0] k);
    {nv_lock_mode_hi, nv_lock_mode_lo, permanent_lock_fuse} = k;
    p0 = pulses;
    arst_n = 1'b0;
    wait_n(2);
    arst_n = 1'b1;
    wait_n(10);
    check("reset pulse", 8'(pulses - p0), 8'h01);
  endtask : arst

  task automatic soft_reset;
    byte_t x;
    p0 = pulses;
    i_spi_host_model.xfer({`OP_RSTEN, 8'h00}, 1, x);
    i_spi_host_model.xfer({`OP_RST, 8'h00}, 1, x);
    check("soft pulse", 8'(pulses - p0), 8'h01);
  endtask : soft_reset

  task automatic chk_lock(logic exp);
    wait_n(6);
    check("locked", {7'h0, status_write_locked}, {7'h0, exp});
  endtask : chk_lock

  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    {arst_n, write_protect_pin_n, hold_reset_pin_n} = 3'b011;
    {nv_lock_mode_hi, nv_lock_mode_lo, permanent_lock_fuse} = 3'b000;
    {error_cnt, tests_run, pulses} = '0;
    void'($urandom(2));
    wait_n(8);
    for (int k = 0; k < 8; k++) begin
      arst(3'(k));
      p = exp_pair(3'(k));
      rd(`OP_RDSR0, v);
      rd(`OP_RDSR2, r);
      check("lock pair", {6'h0, r[0], v[7]}, {6'h0, p});
      check("oe", 8'(i_spi_host_model.oe_seen), 8'h01);
      rd(`OP_RDCFG, v);
      check("cfg reset", v, `CFG_RESET);
      check("strength rst", 8'(output_strength), 8'h01);
      // Corner cases: protect pin low on the pair-00 pass k == 1, pin high on the pair-01 pass k == 3
      write_protect_pin_n = (k == 1) ? 1'b0 : ((k == 3) ? 1'b1 : 1'($urandom));
      lk = exp_lock(p, write_protect_pin_n, 1'b0);
      chk_lock(lk);
      hold_reset_pin_n = 1'b0;
      wait_n(6);
      check("pause", {7'h0, hold_active}, 8'h01);
      hold_reset_pin_n = 1'b1;
      wait_n(6);
      r = 8'($urandom);
      wr(`OP_WRCFG, r);
      e = lk ? `CFG_RESET : r & `CFG_WMASK;
      rd(`OP_RDCFG, v);
      check("cfg write", v, e);
      check("strength", 8'(output_strength), 8'(e[6:5]));
      check("scheme", 8'(protect_scheme_select), 8'(e[2]));
      if (e[2]) wr(r[0] ? `OP_BLKLOCK : `OP_BLKUNLOCK, 8'h00);
      write_protect_pin_n = 1'b1;
      soft_reset();
      chk_lock(p == 2'b11);
      rd(`OP_RDCFG, v);
      check("cfg kept", v, e);
    end
    // Quad mode takes the protect and hold/reset roles away from both pins
    arst(3'b000);
    wr(`OP_WRCFG, 8'h80);
    wr(`OP_WRSR2, 8'h02);
    check("quad", {7'h0, quad_enable}, 8'h01);
    wr(`OP_WRSR0, 8'h80);
    write_protect_pin_n = 1'b0;
    chk_lock(1'b0);
    p0 = pulses;
    hold_reset_pin_n = 1'b0;
    wait_n(8);
    check("quad pin", {7'h0, hold_active}, 8'h00);
    check("quad reset", 8'(pulses - p0), 8'h00);
    hold_reset_pin_n = 1'b1;
    wait_n(6);
    wr(`OP_WRSR2B, 8'h01);
    chk_lock(1'b1);
    wr(`OP_WRCFG, 8'h00);
    rd(`OP_RDCFG, v);
    check("refused", v, 8'h80);
    // Pin acts as hardware reset: reload brings the pair back to 00
    p0 = pulses;
    hold_reset_pin_n = 1'b0;
    wait_n(4);
    hold_reset_pin_n = 1'b1;
    // Sync and reload delay the pulse past the pin release
    wait_n(6);
    check("hw pulse", {7'h0, pulses != p0}, 8'h01);
    chk_lock(1'b0);
    wr(`OP_WRSR2, 8'h01);
    chk_lock(1'b1);
    soft_reset();
    chk_lock(1'b0);
    complete_run();
  end
endmodule : status_write_protect_and_config_test
`default_nettype wire
